// *** dwell_counter.sv ***
// Down counter that times the dwell of one sleep state as 2 to the power N cycles.
`timescale 1ns/1ps
`default_nettype none
module dwell_counter (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic arst_n,
	// Control
	input wire logic load,
	input wire logic [power_sleep_pkg::DWELL_W-1:0] log2Cycles,
	// Status
	output logic expired
);
	import power_sleep_pkg::*;

	typedef struct packed {
		logic [31:0] count;
		logic running;
	} cnt_state_t;

	cnt_state_t cnt_ff;
	cnt_state_t nxt_cnt;

	always_comb begin
		nxt_cnt = cnt_ff;
		if (load) begin
			// Loading 2^N - 1 makes the count reach zero on the last cycle of the state.
			nxt_cnt.count = (DWELL_ONE << log2Cycles) - DWELL_ONE;
			nxt_cnt.running = 1'b1;
		end else if (cnt_ff.running) begin
			if (cnt_ff.count == DWELL_ZERO) begin
				nxt_cnt.running = 1'b0;
			end else begin
				nxt_cnt.count = cnt_ff.count - DWELL_ONE;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_ff <= '0;
		end else begin
			cnt_ff <= nxt_cnt;
		end
	end

	// Expiry is decoded from the count, so the state ends after 2^N edges and not one later.
	assign expired = cnt_ff.running && (cnt_ff.count == DWELL_ZERO);
endmodule : dwell_counter
`default_nettype wire

// *** power_sleep_chk.sv ***
// Port checker for the sleep-state power control block.
`timescale 1ns/1ps
`default_nettype none
module power_sleep_chk
	import power_sleep_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic arst_n,
	// Register port
	input wire logic [7:0] periphNum,
	input wire logic regWr,
	input wire logic regRd,
	input wire logic regAck,
	// Sequencing and controls
	input wire logic sleepReq,
	input wire power_state_t powerState,
	input wire logic tileClkStop,
	input wire logic coreRegEn,
	input wire logic coreRegPfm,
	input wire logic anaRegEn,
	input wire logic anaRegPfm,
	input wire logic ioSupplyEn,
	input wire logic pllRegEn
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!arst_n);
	ack_taken_a: assert property (periphNum == PERIPH_ID && (regWr || regRd) |=> regAck)
		else $error("selected access not acknowledged");
	ack_foreign_a: assert property (!(periphNum == PERIPH_ID && (regWr || regRd)) |=> !regAck)
		else $error("acknowledge without a selected access");
	sleep_entry_a: assert property (powerState == PS_ACTIVE && sleepReq |=> powerState == PS_FIRST_SLEEP)
		else $error("sleep request not taken");
	stay_active_a: assert property (powerState == PS_ACTIVE && !sleepReq |=> powerState == PS_ACTIVE)
		else $error("left active state without request");
	first_next_a: assert property (powerState == PS_FIRST_SLEEP |=> powerState != PS_ACTIVE)
		else $error("first sleep state skipped the second");
	second_from_a: assert property (powerState == PS_SECOND_SLEEP |-> $past(powerState) != PS_ACTIVE)
		else $error("second sleep state entered from active");
	ana_readonly_a: assert property (powerState == PS_FIRST_SLEEP |-> anaRegEn)
		else $error("analogue regulator off in first sleep state");
	active_full_a: assert property (powerState == PS_ACTIVE |-> coreRegEn && anaRegEn && ioSupplyEn
		&& pllRegEn && !tileClkStop && !coreRegPfm && !anaRegPfm)
		else $error("active state not at full power");
	sleep_hold_a: assert property (powerState == PS_FIRST_SLEEP && $past(powerState) == PS_FIRST_SLEEP
		|-> $stable({tileClkStop, coreRegEn, coreRegPfm, anaRegPfm, ioSupplyEn, pllRegEn}))
		else $error("first sleep outputs changed within the state");
	cover property (powerState == PS_FIRST_SLEEP && tileClkStop);
	cover property (powerState == PS_SECOND_SLEEP);
	cover property (regAck && $past(regWr));
endmodule : power_sleep_chk
bind power_sleep_state_control power_sleep_chk i_power_sleep_chk (.ref_clk, .arst_n, .periphNum,
	.regWr, .regRd, .regAck, .sleepReq, .powerState, .tileClkStop, .coreRegEn, .coreRegPfm,
	.anaRegEn, .anaRegPfm, .ioSupplyEn, .pllRegEn);
`default_nettype wire

// *** power_sleep_pkg.sv ***
// Constants and types shared by the sleep-state power control logic.
package power_sleep_pkg;
	localparam logic [7:0] PERIPH_ID = 8'h06;
	localparam logic [7:0] FIRST_SLEEP_OFS = 8'h1c;
	localparam logic [7:0] SECOND_SLEEP_OFS = 8'h20;
	localparam logic [7:0] PLL_LEVEL_OFS = 8'h40;
	// Sleep configuration field positions.
	localparam int DWELL_LSB = 16;
	localparam int DWELL_W = 5;
	localparam int TILE_CLK_OFF_BIT = 14;
	localparam int ANA_PFM_BIT = 9;
	localparam int CORE_PFM_BIT = 8;
	localparam int IO_EN_BIT = 5;
	localparam int PLL_EN_BIT = 4;
	localparam int ANA_EN_BIT = 1;
	localparam int CORE_EN_BIT = 0;
	localparam int PLL_LEVEL_W = 3;
	// Writable bits and reset values of the sleep configuration registers.
	localparam logic [31:0] FIRST_SLEEP_WMASK = 32'h001f_4331;
	localparam logic [31:0] SECOND_SLEEP_WMASK = 32'h001f_4333;
	localparam logic [31:0] SLEEP_RESET = 32'h0010_0022;
	localparam logic [31:0] DWELL_ONE = 32'h0000_0001;
	localparam logic [31:0] DWELL_ZERO = 32'h0000_0000;
	typedef enum logic [1:0] {
		PS_ACTIVE = 2'b00,
		PS_FIRST_SLEEP = 2'b01,
		PS_SECOND_SLEEP = 2'b10
	} power_state_t;
endpackage : power_sleep_pkg

// *** power_sleep_state_control.sv ***
// Sleep-state configuration registers and sequencing of the power control block.
`timescale 1ns/1ps
`default_nettype none
// Function
// - Registers answer as peripheral 6, whole 32-bit reads and writes only.
// - Dwell field N keeps the first sleep state for 2^N cycles, reset 16.
// - Bit 14 stops the processor tile clock in the first sleep state.
// - Bit 9 picks PWM or PFM for the analogue regulator in sleep.
// - Bit 8 picks PWM or PFM for the core regulator in sleep.
// - Bit 5 enables the I/O supply output in sleep, resets to one.
// - Bit 4 enables the PLL linear regulator in sleep, resets to zero.
// - Bit 1 shows the analogue regulator enable, read-only at 0x1c but writable at 0x20, resets to one.
// - Bit 0 enables the core regulator in sleep, resets to zero.
// - Register at 0x20 sets second sleep state settings and its dwell.
// - Three-bit PLL regulator level is 0.6 V plus 100 mV per step.
module power_sleep_state_control (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic arst_n,
	// Peripheral register port
	input wire logic [7:0] periphNum,
	input wire logic regWr,
	input wire logic regRd,
	input wire logic [7:0] regAddr,
	input wire logic [31:0] regWdata,
	output logic [31:0] regRdata,
	output logic regAck,
	// Power sequencing
	input wire logic sleepReq,
	input wire logic [power_sleep_pkg::PLL_LEVEL_W-1:0] pllLevelStrap,
	output power_sleep_pkg::power_state_t powerState,
	// Regulator and clock controls
	output logic tileClkStop,
	output logic coreRegEn,
	output logic coreRegPfm,
	output logic anaRegEn,
	output logic anaRegPfm,
	output logic ioSupplyEn,
	output logic pllRegEn,
	output logic [power_sleep_pkg::PLL_LEVEL_W-1:0] pllRegLevel
);
	import power_sleep_pkg::*;

	typedef struct packed {
		logic [31:0] firstSleep;
		logic [31:0] secondSleep;
		// Level register and the flag that says the strap has been taken into it.
		logic [PLL_LEVEL_W-1:0] pllLevel;
		logic strapTaken;
		power_state_t state;
		logic [31:0] rdata;
		logic ack;
		logic tileClkStop;
		logic coreRegEn;
		logic coreRegPfm;
		logic anaRegEn;
		logic anaRegPfm;
		logic ioSupplyEn;
		logic pllRegEn;
		logic [PLL_LEVEL_W-1:0] pllRegLevel;
	} ctl_state_t;

	ctl_state_t ctl_ff;
	ctl_state_t nxt_ctl;
	logic dwellLoad;
	logic [DWELL_W-1:0] dwellLog2;
	logic dwellExpired;
	logic selected;
	logic [31:0] cfg;

	// The counter is shared: only one sleep state is ever timed at a time.
	dwell_counter dwellTimer (
		.ref_clk(ref_clk),
		.arst_n(arst_n),
		.load(dwellLoad),
		.log2Cycles(dwellLog2),
		.expired(dwellExpired)
	);

	// Accesses for any other peripheral number pass by without an acknowledge.
	assign selected = (periphNum == PERIPH_ID);

	always_comb begin
		nxt_ctl = ctl_ff;
		dwellLoad = 1'b0;
		dwellLog2 = ctl_ff.firstSleep[DWELL_LSB +: DWELL_W];
		nxt_ctl.ack = 1'b0;
		// The level reset value follows a strap that is only stable after reset.
		if (!ctl_ff.strapTaken) begin
			nxt_ctl.pllLevel = pllLevelStrap;
			nxt_ctl.strapTaken = 1'b1;
		end
		// A write wins over a read in the same cycle; unmapped offsets are still acknowledged.
		if (selected && regWr) begin
			nxt_ctl.ack = 1'b1;
			case (regAddr)
				FIRST_SLEEP_OFS: begin
					// Bit 1 is outside the write mask and holds its reset value.
					nxt_ctl.firstSleep = (ctl_ff.firstSleep & ~FIRST_SLEEP_WMASK)
						| (regWdata & FIRST_SLEEP_WMASK);
				end
				SECOND_SLEEP_OFS: begin
					nxt_ctl.secondSleep = regWdata & SECOND_SLEEP_WMASK;
				end
				PLL_LEVEL_OFS: begin
					nxt_ctl.pllLevel = regWdata[PLL_LEVEL_W-1:0];
					nxt_ctl.strapTaken = 1'b1;
				end
				default: begin
				end
			endcase
		end else if (selected && regRd) begin
			nxt_ctl.ack = 1'b1;
			case (regAddr)
				FIRST_SLEEP_OFS: begin
					nxt_ctl.rdata = ctl_ff.firstSleep;
				end
				SECOND_SLEEP_OFS: begin
					nxt_ctl.rdata = ctl_ff.secondSleep;
				end
				PLL_LEVEL_OFS: begin
					// The unused upper bits read as zero.
					nxt_ctl.rdata = {{(32-PLL_LEVEL_W){1'b0}}, ctl_ff.pllLevel};
				end
				default: begin
					nxt_ctl.rdata = '0;
				end
			endcase
		end
		// A sleep request is only looked at while active; each dwell is taken at entry.
		case (ctl_ff.state)
			PS_ACTIVE: begin
				if (sleepReq) begin
					nxt_ctl.state = PS_FIRST_SLEEP;
					dwellLoad = 1'b1;
					dwellLog2 = ctl_ff.firstSleep[DWELL_LSB +: DWELL_W];
				end
			end
			PS_FIRST_SLEEP: begin
				if (dwellExpired) begin
					nxt_ctl.state = PS_SECOND_SLEEP;
					dwellLoad = 1'b1;
					dwellLog2 = ctl_ff.secondSleep[DWELL_LSB +: DWELL_W];
				end
			end
			PS_SECOND_SLEEP: begin
				// No load here: the counter stops by itself once it has run out.
				if (dwellExpired) begin
					nxt_ctl.state = PS_ACTIVE;
				end
			end
			default: begin
				nxt_ctl.state = PS_ACTIVE;
			end
		endcase
		// Outside sleep everything runs at full strength with the tile clocked.
		case (nxt_ctl.state)
			PS_FIRST_SLEEP: begin
				cfg = ctl_ff.firstSleep;
			end
			PS_SECOND_SLEEP: begin
				cfg = ctl_ff.secondSleep;
			end
			default: begin
				cfg = '0;
			end
		endcase
		// Settings are taken on entry only, so a sleep register write while asleep cannot move a regulator; pllRegLevel follows writes at once.
		if (nxt_ctl.state != ctl_ff.state) begin
			if (nxt_ctl.state == PS_ACTIVE) begin
				nxt_ctl.tileClkStop = 1'b0;
				nxt_ctl.coreRegEn = 1'b1;
				nxt_ctl.coreRegPfm = 1'b0;
				nxt_ctl.anaRegEn = 1'b1;
				nxt_ctl.anaRegPfm = 1'b0;
				nxt_ctl.ioSupplyEn = 1'b1;
				nxt_ctl.pllRegEn = 1'b1;
			end else begin
				nxt_ctl.tileClkStop = cfg[TILE_CLK_OFF_BIT];
				nxt_ctl.anaRegPfm = cfg[ANA_PFM_BIT];
				nxt_ctl.coreRegPfm = cfg[CORE_PFM_BIT];
				nxt_ctl.ioSupplyEn = cfg[IO_EN_BIT];
				nxt_ctl.pllRegEn = cfg[PLL_EN_BIT];
				nxt_ctl.anaRegEn = cfg[ANA_EN_BIT];
				nxt_ctl.coreRegEn = cfg[CORE_EN_BIT];
			end
		end
		nxt_ctl.pllRegLevel = nxt_ctl.pllLevel;
	end

	// Reset puts the regulators at full strength before any software has run.
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			ctl_ff <= '0;
			ctl_ff.firstSleep <= SLEEP_RESET;
			ctl_ff.secondSleep <= SLEEP_RESET;
			ctl_ff.state <= PS_ACTIVE;
			ctl_ff.coreRegEn <= 1'b1;
			ctl_ff.anaRegEn <= 1'b1;
			ctl_ff.ioSupplyEn <= 1'b1;
			ctl_ff.pllRegEn <= 1'b1;
		end else begin
			ctl_ff <= nxt_ctl;
		end
	end

	// Every output is a plain copy of a register, so none of them can glitch.
	assign regRdata = ctl_ff.rdata;
	assign regAck = ctl_ff.ack;
	assign powerState = ctl_ff.state;
	assign tileClkStop = ctl_ff.tileClkStop;
	assign coreRegEn = ctl_ff.coreRegEn;
	assign coreRegPfm = ctl_ff.coreRegPfm;
	assign anaRegEn = ctl_ff.anaRegEn;
	assign anaRegPfm = ctl_ff.anaRegPfm;
	assign ioSupplyEn = ctl_ff.ioSupplyEn;
	assign pllRegEn = ctl_ff.pllRegEn;
	assign pllRegLevel = ctl_ff.pllRegLevel;
endmodule : power_sleep_state_control
`default_nettype wire

// *** sleep_supply_model.sv ***
// Behavioural regulators and tile clock gate fed by the sleep controls.
`timescale 1ns/1ps
`default_nettype none
module sleep_supply_model (
	// Controls from the block
	input wire logic ref_clk,
	input wire logic tileClkStop,
	input wire logic coreRegEn,
	input wire logic coreRegPfm,
	input wire logic anaRegEn,
	input wire logic anaRegPfm,
	// Gated clock and load capability in mA
	output logic tileClk,
	output var int coreMaxMa,
	output var int anaMaxMa
);
	// A disabled regulator sources nothing, whatever its modulation.
	assign tileClk = ref_clk & ~tileClkStop;
	assign coreMaxMa = !coreRegEn ? 0 : coreRegPfm ? 50 : 700;
	assign anaMaxMa = !anaRegEn ? 0 : anaRegPfm ? 50 : 475;
endmodule : sleep_supply_model
`default_nettype wire

// *** tb.sv ***
// Self-checking testbench for the sleep-state power control block.
`timescale 1ns/1ps
`default_nettype none
module tb;
	import power_sleep_pkg::*;
	logic ref_clk = 1'b0;
	logic arst_n = 1'b0;
	logic [7:0] periphNum = PERIPH_ID;
	logic regWr = 1'b0;
	logic regRd = 1'b0;
	logic [7:0] regAddr = 8'h00;
	logic [31:0] regWdata = 32'h0000_0000;
	logic sleepReq = 1'b0;
	logic [2:0] pllLevelStrap = 3'h5;
	logic [31:0] regRdata;
	logic regAck, tileClkStop, coreRegEn, coreRegPfm, anaRegEn, anaRegPfm, ioSupplyEn, pllRegEn;
	logic [2:0] pllRegLevel;
	power_state_t powerState;
	logic tileClk;
	int coreMaxMa, anaMaxMa;
	int err_count = 0;
	int n_compared = 0;
	power_sleep_state_control i_power_sleep_state_control (.ref_clk, .arst_n, .periphNum, .regWr,
		.regRd, .regAddr, .regWdata, .regRdata, .regAck, .sleepReq, .pllLevelStrap, .powerState,
		.tileClkStop, .coreRegEn, .coreRegPfm, .anaRegEn, .anaRegPfm, .ioSupplyEn, .pllRegEn,
		.pllRegLevel);
	sleep_supply_model i_sleep_supply_model (.ref_clk, .tileClkStop, .coreRegEn, .coreRegPfm,
		.anaRegEn, .anaRegPfm, .tileClk, .coreMaxMa, .anaMaxMa);
	initial begin
		forever #2.5 ref_clk = ~ref_clk;
	end
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			err_count++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	// Request is held for exactly one edge; the answer is taken while regAck stands.
	task automatic access(input logic wr, input logic [7:0] pn, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] rd, output logic ack);
		@(negedge ref_clk);
		periphNum = pn;
		regWr = wr;
		regRd = ~wr;
		regAddr = a;
		regWdata = d;
		@(negedge ref_clk);
		ack = regAck;
		rd = regRdata;
		regWr = 1'b0;
		regRd = 1'b0;
	endtask : access
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] rd;
		logic ack;
		access(1'b1, PERIPH_ID, a, d, rd, ack);
		chk("write regAck", 32'h1, ack);
	endtask : wr
	task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] rd;
		logic ack;
		access(1'b0, PERIPH_ID, a, 32'h0, rd, ack);
		chk("read regAck", 32'h1, ack);
		chk("regRdata", e, rd);
	endtask : rdchk
	function automatic logic [6:0] want(input logic [31:0] c);
		return {c[14], c[0], c[8], c[1], c[9], c[5], c[4]};
	endfunction : want
	function automatic logic [6:0] outs();
		return {tileClkStop, coreRegEn, coreRegPfm, anaRegEn, anaRegPfm, ioSupplyEn, pllRegEn};
	endfunction : outs
	task automatic t_reset;
		chk("active outputs", 32'h2b, outs());
		rdchk(FIRST_SLEEP_OFS, SLEEP_RESET);
		rdchk(SECOND_SLEEP_OFS, SLEEP_RESET);
		rdchk(PLL_LEVEL_OFS, 32'h0000_0005);
		chk("pllRegLevel", 32'h5, pllRegLevel);
		$display("test reset values done");
	endtask : t_reset
	task automatic t_regs;
		logic [31:0] rd;
		logic ack;
		wr(FIRST_SLEEP_OFS, 32'hffff_ffff);
		rdchk(FIRST_SLEEP_OFS, 32'h001f_4333);
		wr(FIRST_SLEEP_OFS, 32'h0000_0000);
		rdchk(FIRST_SLEEP_OFS, 32'h0000_0002);
		wr(SECOND_SLEEP_OFS, 32'hffff_ffff);
		rdchk(SECOND_SLEEP_OFS, 32'h001f_4333);
		wr(PLL_LEVEL_OFS, 32'hffff_ffff);
		rdchk(PLL_LEVEL_OFS, 32'h0000_0007);
		chk("pllRegLevel", 32'h7, pllRegLevel);
		access(1'b1, 8'h05, PLL_LEVEL_OFS, 32'h0, rd, ack);
		chk("foreign regAck", 32'h0, ack);
		rdchk(PLL_LEVEL_OFS, 32'h0000_0007);
		rdchk(8'h44, 32'h0000_0000);
		$display("test register access done");
	endtask : t_regs
	task automatic sleep_run(input logic [31:0] c1, input logic [31:0] c2);
		int n;
		wr(FIRST_SLEEP_OFS, c1);
		wr(SECOND_SLEEP_OFS, c2);
		@(negedge ref_clk);
		sleepReq = 1'b1;
		@(posedge ref_clk);
		#1;
		chk("tileClk", {31'h0, ~c1[14]}, tileClk);
		@(negedge ref_clk);
		sleepReq = 1'b0;
		chk("first outputs", want(c1), outs());
		chk("core load", c1[0] ? (c1[8] ? 50 : 700) : 0, coreMaxMa);
		chk("analogue load", c1[9] ? 50 : 475, anaMaxMa);
		for (n = 0; powerState === PS_FIRST_SLEEP && n < 100; n++) @(negedge ref_clk);
		chk("first dwell", (1 << c1[20:16]), n);
		chk("second outputs", want(c2), outs());
		for (n = 0; powerState === PS_SECOND_SLEEP && n < 100; n++) @(negedge ref_clk);
		chk("second dwell", (1 << c2[20:16]), n);
		chk("powerState", PS_ACTIVE, powerState);
		chk("active outputs", 32'h2b, outs());
		$display("test sleep sequence done");
	endtask : sleep_run
	task automatic complete_run;
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : complete_run
	initial begin
		#50000;
		err_count++;
		complete_run();
	end
	initial begin
		repeat (5) @(posedge ref_clk);
		@(negedge ref_clk);
		arst_n = 1'b1;
		t_reset();
		t_regs();
		sleep_run(32'h0002_4313, 32'h0000_0022);
		sleep_run(32'h0000_0003, 32'h0001_4021);
		complete_run();
	end
endmodule : tb
`default_nettype wire
